//--- src/hall_sensor_primary_registers.sv
// Purpose: Primary volatile register bank of a three-axis field sensor
// Assumes: Serial engine outside issues one-cycle read and write strobes
// Notes: Measurement core feeds whole samples; unmapped reads give zero
`timescale 1ns/1ns
`default_nettype none
`include "hall_regs_defines.svh"
module hall_sensor_primary_registers
  import hall_regs_pkg::*;
#(
  parameter int ADDR_W = 8 // Register address width
)(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic accessEnabled,
  input wire logic rdStrobe,
  input wire logic wrStrobe,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] wrData,
  output logic [31:0] rdData,
  output logic rdValid,
  input wire logic sampleValid,
  input wire logic [11:0] fieldX,
  input wire logic [11:0] fieldY,
  input wire logic [11:0] fieldZ,
  input wire logic [11:0] tempValue,
  input wire logic [1:0] hallConfig,
  input wire logic thresholdCrossed,
  input wire logic intHoldEn,
  input wire logic intRecordEn,
  input wire logic recordWriteDone,
  output logic recordWriteStart,
  output logic intPin_n,
  output logic [1:0] operatingMode,
  output logic [1:0] readbackLoop,
  output logic [2:0] inactiveCountMax
);
  // Refuse address widths that cannot reach the bank
  if (ADDR_W < 6) begin : g_chk
    $error("ADDR_W too small for register offsets");
  end

  // Pack the high register from one sample
  function automatic logic [31:0] packHigh(input logic [11:0] x,
      input logic [11:0] y, input logic [11:0] z, input logic [11:0] t,
      input logic nd, input logic ia);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`HIGH_X_LSB +: 8] = x[11:4];
    v[`HIGH_Y_LSB +: 8] = y[11:4];
    v[`HIGH_Z_LSB +: 8] = z[11:4];
    v[`HIGH_NEW_BIT] = nd;
    v[`HIGH_INT_BIT] = ia;
    v[`HIGH_TEMP_LSB +: 6] = t[11:6];
    return v;
  endfunction

  // Pack the low register; bits 31:21 stay zero
  function automatic logic [31:0] packLow(input logic [11:0] x,
      input logic [11:0] y, input logic [11:0] z, input logic [11:0] t,
      input logic [1:0] hm, input logic bsy);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`LOW_BUSY_BIT] = bsy;
    v[`LOW_X_LSB +: 4] = x[3:0];
    v[`LOW_Y_LSB +: 4] = y[3:0];
    v[`LOW_Z_LSB +: 4] = z[3:0];
    v[`LOW_HALL_LSB +: 2] = hm;
    v[`LOW_TEMP_LSB +: 6] = t[5:0];
    return v;
  endfunction

  logic [6:0] ctrl_q; // Control register, bits 6:0 only
  logic [6:0] ctrl_d;
  logic [11:0] xHi_q, yHi_q, zHi_q, tHi_q; // Sample behind high register
  logic [11:0] xLo_q, yLo_q, zLo_q, tLo_q; // Sample behind low register
  logic [1:0] hallLo_q; // Configuration behind low register
  logic [1:0] hallHi_q; // Configuration of the latest sample
  logic pairHold_q; // High part read, low part pending
  logic newData_q; // Fresh update flag
  logic intStatus_q; // Interrupt status bit
  logic intStatus_d;
  logic crossedPrev_q; // Last crossing level, for edge
  logic [31:0] rdData_q; // Read data register
  logic rdValid_q; // Read answer pulse
  logic intPin_n_q; // Interrupt pin register
  logic [6:0] ctrlOut_q; // Registered control outputs
  op_mode_t curMode; // Decoded operating mode
  intr_rec_if rec (); // Link to record tracker

  // Address decode
  wire logic hitCtrl = (regAddr == ADDR_W'(`OFS_CTRL));
  wire logic hitHigh = (regAddr == ADDR_W'(`OFS_HIGH));
  wire logic hitLow = (regAddr == ADDR_W'(`OFS_LOW));
  wire logic wrCtrl = wrStrobe && hitCtrl;
  wire logic wrHigh = wrStrobe && hitHigh && accessEnabled;
  wire logic rdHigh = rdStrobe && hitHigh;
  wire logic rdLow = rdStrobe && hitLow;

  // Sleep holds results still; other modes update
  assign curMode = op_mode_t'(ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
  wire logic sleeping = (curMode == MODE_SLEEP);
  wire logic sampleOk = sampleValid && !sleeping;

  // Crossing edge launches the record write
  wire logic crossRise = thresholdCrossed && !crossedPrev_q;
  wire logic intClear = wrHigh && wrData[`HIGH_INT_BIT];

  // Low register follows the sample unless a pair read is open
  wire logic lowLoad = sampleOk && !pairHold_q;

  // Control write: mode always, the rest only under access
  always_comb begin
    ctrl_d = ctrl_q;
    if (wrCtrl) begin
      ctrl_d[`CTRL_MODE_MSB:`CTRL_MODE_LSB] =
        wrData[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
      if (accessEnabled) begin
        ctrl_d[`CTRL_INACT_MSB:`CTRL_LOOP_LSB] =
          wrData[`CTRL_INACT_MSB:`CTRL_LOOP_LSB];
      end
    end
  end

  // Interrupt status: held sticky or following the condition
  always_comb begin
    if (intHoldEn) begin
      // Set wins over a same-cycle clear
      intStatus_d = thresholdCrossed || (intStatus_q && !intClear);
    end else begin
      intStatus_d = thresholdCrossed;
    end
  end

  // Control register and its outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q <= `CTRL_RESET;
      ctrlOut_q <= `CTRL_RESET;
    end else if (clkEn) begin
      ctrl_q <= ctrl_d;
      ctrlOut_q <= ctrl_d;
    end
  end

  // High-side sample capture
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      xHi_q <= 12'h000;
      yHi_q <= 12'h000;
      zHi_q <= 12'h000;
      tHi_q <= 12'h000;
      hallHi_q <= 2'h0;
    end else if (clkEn && sampleOk) begin
      xHi_q <= fieldX;
      yHi_q <= fieldY;
      zHi_q <= fieldZ;
      tHi_q <= tempValue;
      hallHi_q <= hallConfig;
    end
  end

  // Low-side sample capture, kept paired with the high read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      xLo_q <= 12'h000;
      yLo_q <= 12'h000;
      zLo_q <= 12'h000;
      tLo_q <= 12'h000;
      hallLo_q <= 2'h0;
    end else if (clkEn && rdHigh) begin
      // Freeze the low part with the sample just read high
      xLo_q <= xHi_q;
      yLo_q <= yHi_q;
      zLo_q <= zHi_q;
      tLo_q <= tHi_q;
      // Configuration must follow the same sample as the fields
      hallLo_q <= hallHi_q;
    end else if (clkEn && lowLoad) begin
      xLo_q <= fieldX;
      yLo_q <= fieldY;
      zLo_q <= fieldZ;
      tLo_q <= tempValue;
      hallLo_q <= hallConfig;
    end
  end

  // Pair hold: opened by high read, closed by low read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pairHold_q <= 1'b0;
    end else if (clkEn) begin
      pairHold_q <= rdHigh || (pairHold_q && !rdLow);
    end
  end

  // Flags; an update wins over the read that clears
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      newData_q <= 1'b0;
      intStatus_q <= 1'b0;
      crossedPrev_q <= 1'b0;
      intPin_n_q <= 1'b1;
    end else if (clkEn) begin
      newData_q <= sampleOk || (newData_q && !rdHigh);
      intStatus_q <= intStatus_d;
      crossedPrev_q <= thresholdCrossed;
      intPin_n_q <= !intStatus_d;
    end
  end

  // Read answer; every register readable regardless of access
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdData_q <= 32'h0000_0000;
      rdValid_q <= 1'b0;
    end else if (clkEn) begin
      rdValid_q <= rdStrobe;
      if (rdStrobe) begin
        if (hitCtrl) rdData_q <= {25'h0, ctrl_q};
        else if (hitHigh) rdData_q <= packHigh(xHi_q, yHi_q, zHi_q,
                                               tHi_q, newData_q,
                                               intStatus_q);
        else if (hitLow) rdData_q <= packLow(xLo_q, yLo_q, zLo_q,
                                             tLo_q, hallLo_q, rec.busy);
        else rdData_q <= 32'h0000_0000; // Unmapped offset
      end
    end
  end

  // Record tracker hookup
  assign rec.trigger = crossRise;
  assign rec.recordEn = intRecordEn;
  assign rec.writeDone = recordWriteDone;

  intr_record_tracker u_tracker (
    .clk_sys(clk_sys),
    .reset(reset),
    .clkEn(clkEn),
    .rec(rec)
  );

  // Outputs straight from flops
  assign rdData = rdData_q;
  assign rdValid = rdValid_q;
  assign recordWriteStart = rec.writeStart;
  assign intPin_n = intPin_n_q;
  assign operatingMode = ctrlOut_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
  assign readbackLoop = ctrlOut_q[`CTRL_LOOP_MSB:`CTRL_LOOP_LSB];
  assign inactiveCountMax = ctrlOut_q[`CTRL_INACT_MSB:`CTRL_INACT_LSB];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  read_answer_a: assert property (
    clkEn && rdStrobe |=> rdValid)
    else $error("read not answered next cycle");
  locked_write_a: assert property (
    clkEn && wrCtrl && !accessEnabled |=> inactiveCountMax ==
      $past(inactiveCountMax) && readbackLoop == $past(readbackLoop))
    else $error("locked control fields changed");
  mode_write_a: assert property (
    clkEn && wrCtrl |=> operatingMode == $past(wrData[1:0]))
    else $error("mode field not written");
  newdata_set_a: assert property (
    clkEn && sampleOk ##1 clkEn && rdHigh |=> rdData[7])
    else $error("new data flag missing");
  newdata_clear_a: assert property (
    clkEn && rdHigh && !sampleOk |=> !newData_q)
    else $error("new data flag not cleared by read");
  int_hold_a: assert property (
    clkEn && intHoldEn && intStatus_q && !intClear |=> intStatus_q)
    else $error("held interrupt dropped");
  int_pin_a: assert property (
    intPin_n == !intStatus_q)
    else $error("interrupt pin differs from status");
  ctrl_reserved_a: assert property (
    clkEn && rdStrobe && hitCtrl |=> rdData[31:7] == 25'h0)
    else $error("control reserved bits nonzero");
  low_reserved_a: assert property (
    clkEn && rdStrobe && hitLow |=> rdData[31:21] == 11'h0)
    else $error("low reserved bits nonzero");
  pair_hold_a: assert property (
    clkEn && rdHigh ##1 (clkEn && !rdLow && !rdHigh)[*1]
      |=> $stable(xLo_q))
    else $error("low part changed inside pair read");

  pair_read_c: cover property (rdHigh ##[1:8] rdLow);
  int_w1c_c: cover property (intHoldEn && intStatus_q ##1 intClear);
  sleep_c: cover property (sleeping && sampleValid);
endmodule
`default_nettype wire

//--- src/hall_regs_defines.svh
// Purpose: Offsets, field positions and reset values of the primary bank
// Assumes: Included by its bare name from the package and the bank module
// Notes: Definitions only
`ifndef HALL_REGS_DEFINES_SVH
`define HALL_REGS_DEFINES_SVH

// Register offsets on the register port
`define OFS_CTRL 8'h27
`define OFS_HIGH 8'h28
`define OFS_LOW 8'h29

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_LOOP_LSB 2
`define CTRL_LOOP_MSB 3
`define CTRL_INACT_LSB 4
`define CTRL_INACT_MSB 6
`define CTRL_RESET 7'h00

// High result register fields
`define HIGH_X_LSB 24
`define HIGH_Y_LSB 16
`define HIGH_Z_LSB 8
`define HIGH_NEW_BIT 7
`define HIGH_INT_BIT 6
`define HIGH_TEMP_LSB 0

// Low result register fields
`define LOW_BUSY_BIT 20
`define LOW_X_LSB 16
`define LOW_Y_LSB 12
`define LOW_Z_LSB 8
`define LOW_HALL_LSB 6
`define LOW_TEMP_LSB 0

`endif

//--- src/hall_regs_pkg.sv
// Purpose: Shared types of the primary register bank
// Assumes: Defines header sits on the include path
// Notes: Encodings of the mode fields
`include "hall_regs_defines.svh"
package hall_regs_pkg;
  // Operating mode field decode
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_DUTY_CYCLED_LOW_POWER = 2'h2,
    MODE_UNUSED = 2'h3
  } op_mode_t;
  // Serial readback behaviour
  typedef enum logic [1:0] {
    LOOP_SINGLE = 2'h0,
    LOOP_FAST = 2'h1,
    LOOP_FULL = 2'h2,
    LOOP_UNUSED = 2'h3
  } loop_mode_t;
  // Record tracker states
  typedef enum logic {
    REC_IDLE,
    REC_BUSY
  } rec_state_t;
endpackage

//--- src/intr_rec_if.sv
// Purpose: Carrier between the bank and the interrupt record tracker
// Assumes: Single clock domain
// Notes: Start is a one-cycle pulse, busy is a level
`timescale 1ns/1ns
`default_nettype none
interface intr_rec_if;
  logic trigger; // Rising interrupt event, one cycle
  logic recordEn; // Record on interrupt enabled
  logic writeDone; // Non-volatile write finished
  logic writeStart; // Launch non-volatile write
  logic busy; // Write in progress
  modport tracker(input trigger, input recordEn, input writeDone,
                  output writeStart, output busy);
  modport owner(output trigger, output recordEn, output writeDone,
                input writeStart, input busy);
endinterface
`default_nettype wire

//--- src/intr_record_tracker.sv
// Purpose: Tracks the non-volatile interrupt record write
// Assumes: Writer answers each start with one done pulse
// Notes: Further events while busy are absorbed
`timescale 1ns/1ns
`default_nettype none
module intr_record_tracker
  import hall_regs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEn,
  intr_rec_if.tracker rec
);
  rec_state_t state_q; // Tracker state
  rec_state_t state_d;
  logic start_q; // Start pulse register
  wire logic launch; // New write begins
  wire logic finish; // Write completes

  // Only launch from idle so one write is in flight
  assign launch = (state_q == REC_IDLE) && rec.trigger && rec.recordEn;
  assign finish = (state_q == REC_BUSY) && rec.writeDone;
  assign rec.busy = (state_q == REC_BUSY);
  assign rec.writeStart = start_q;

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      REC_IDLE: begin
        if (launch) state_d = REC_BUSY;
      end
      REC_BUSY: begin
        if (finish) state_d = REC_IDLE;
      end
      default: state_d = REC_IDLE;
    endcase
  end

  // State and start pulse
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= REC_IDLE;
      start_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      start_q <= launch;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  busy_clears_a: assert property (
    clkEn && finish |=> !rec.busy)
    else $error("record busy did not clear after done");
  busy_sets_a: assert property (
    clkEn && launch |=> rec.busy && rec.writeStart)
    else $error("record write not started on event");
  rec_cycle_c: cover property (launch ##[1:50] finish);
endmodule
`default_nettype wire

//--- tb/host_model.sv
// Purpose: Register host that reads and configures the primary bank
// Assumes: Strobes are taken on the rising edge, read answer one cycle on
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk_sys,
  output logic rdStrobe,
  output logic wrStrobe,
  output logic [7:0] regAddr,
  output logic [31:0] wrData,
  output logic accessEnabled,
  input wire logic [31:0] rdData,
  input wire logic rdValid
);
  // Idle port at time zero
  initial begin
    rdStrobe = 1'b0;
    wrStrobe = 1'b0;
    regAddr = 8'h00;
    wrData = 32'h00000000;
    accessEnabled = 1'b0;
  end
  // Access mode before any write beyond the mode field
  task automatic set_access(input logic en);
    @(posedge clk_sys);
    #2;
    accessEnabled = en;
  endtask
  // One write strobe, data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #2;
    wrStrobe = 1'b1;
    regAddr = a;
    wrData = d;
    @(posedge clk_sys);
    #2;
    wrStrobe = 1'b0;
    regAddr = ~a;
    wrData = ~d;
  endtask
  // One read; an absent answer comes back unknown so it never matches
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    #2;
    rdStrobe = 1'b1;
    regAddr = a;
    @(posedge clk_sys);
    #2;
    rdStrobe = 1'b0;
    regAddr = ~a;
    d = (rdValid === 1'b1) ? rdData : 32'hXXXXXXXX;
  endtask
  // High then low back to back, one sample for both halves
  task automatic rd_pair(output logic [31:0] hi, output logic [31:0] lo);
    rd(8'h28, hi);
    rd(8'h29, lo);
  endtask
endmodule
`default_nettype wire

//--- tb/hall_sensor_primary_registers_tb.sv
// Purpose: Self-checking bench of the primary register bank
// Assumes: Host model drives the register port, bench drives the rest
// Notes: Expected words rebuilt from integers held by the bench
`timescale 1ns/1ns
`default_nettype none
module hall_sensor_primary_registers_tb;
  import hall_regs_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic rdStrobe, wrStrobe, accessEnabled, rdValid;
  logic [7:0] regAddr;
  logic [31:0] wrData, rdData, hi, lo, v;
  logic sampleValid = 1'b0;
  logic [11:0] fieldX = 12'h000, fieldY = 12'h000;
  logic [11:0] fieldZ = 12'h000, tempValue = 12'h000;
  logic [1:0] hallConfig = 2'h0;
  logic thresholdCrossed = 1'b0, intHoldEn = 1'b0, intRecordEn = 1'b0;
  logic recordWriteDone = 1'b0;
  logic clkEn = 1'b1;
  logic recordWriteStart, intPin_n;
  logic [1:0] operatingMode, readbackLoop;
  logic [2:0] inactiveCountMax;
  int n_errors = 0, num_checks = 0;
  // Bench model state
  int ctrl = 0, sx = 0, sy = 0, sz = 0, st = 0, hm = 0, nd = 0, busy = 0;
  int seen;
  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;
  host_model host (.clk_sys(clk_sys), .rdStrobe(rdStrobe),
    .wrStrobe(wrStrobe), .regAddr(regAddr), .wrData(wrData),
    .accessEnabled(accessEnabled), .rdData(rdData), .rdValid(rdValid));
  // Clock enable driven by the bench so the freeze is exercised
  hall_sensor_primary_registers dut (.clk_sys(clk_sys), .reset(reset),
    .clkEn(clkEn), .accessEnabled(accessEnabled), .rdStrobe(rdStrobe),
    .wrStrobe(wrStrobe), .regAddr(regAddr), .wrData(wrData),
    .rdData(rdData), .rdValid(rdValid), .sampleValid(sampleValid),
    .fieldX(fieldX), .fieldY(fieldY), .fieldZ(fieldZ),
    .tempValue(tempValue), .hallConfig(hallConfig),
    .thresholdCrossed(thresholdCrossed), .intHoldEn(intHoldEn),
    .intRecordEn(intRecordEn), .recordWriteDone(recordWriteDone),
    .recordWriteStart(recordWriteStart), .intPin_n(intPin_n),
    .operatingMode(operatingMode), .readbackLoop(readbackLoop),
    .inactiveCountMax(inactiveCountMax));
  // Single comparison point
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // Expected packed words
  function automatic logic [31:0] hiw(input int ia);
    hiw = {sx[11:4], sy[11:4], sz[11:4], nd[0], ia[0], st[11:6]};
  endfunction
  function automatic logic [31:0] low();
    low = {11'h000, busy[0], sx[3:0], sy[3:0], sz[3:0], hm[1:0], st[5:0]};
  endfunction
  // One measurement; sleep drops it
  task automatic put_sample();
    @(posedge clk_sys);
    #2;
    sampleValid = 1'b1;
    fieldX = 12'($urandom);
    fieldY = 12'($urandom);
    fieldZ = 12'($urandom);
    tempValue = 12'($urandom);
    hallConfig = ($urandom % 2) ? 2'h2 : 2'h0;
    if (ctrl[1:0] != 1) begin
      sx = fieldX;
      sy = fieldY;
      sz = fieldZ;
      st = tempValue;
      hm = hallConfig;
      nd = 1;
    end
    tick(1);
    sampleValid = 1'b0;
  endtask
  task automatic wr_ctrl(input logic [31:0] d);
    host.wr(8'h27, d);
    if (accessEnabled === 1'b1) ctrl = d & 32'h7F;
    else ctrl = (ctrl & 32'h7C) | (d & 32'h3);
    host.rd(8'h27, v);
    check(v, 32'(ctrl));
    check(32'({inactiveCountMax, readbackLoop, operatingMode}),
          32'(ctrl));
  endtask
  // Watchdog
  initial begin
    #(4000 * 50);
    n_errors++;
    close_out();
  end
  // Main sequence
  initial begin
    void'($urandom(85404));
    tick(20);
    reset = 1'b0;
    host.rd(8'h27, v);
    check(v, 32'h00000000);
    check(32'(intPin_n), 32'h1);
    host.rd(8'h30, v);
    check(v, 32'h00000000);
    $display("reset test done");
    // Locked: only the mode field moves
    wr_ctrl(32'hFFFFFFFF);
    wr_ctrl(32'hFFFFFF72);
    host.set_access(1'b1);
    for (int i = 0; i < 8; i++) begin
      wr_ctrl(32'hFFFFFF80 | (i << 4) | ((i % 3) << 2) | (i % 3));
    end
    wr_ctrl(32'h00000000);
    // Frozen clock enable drops a mode write
    clkEn = 1'b0;
    host.wr(8'h27, 32'h00000001);
    clkEn = 1'b1;
    host.rd(8'h27, v);
    check(v, 32'(ctrl));
    $display("control test done");
    // Sample readback, read-clear of new data
    put_sample();
    host.rd_pair(hi, lo);
    check(hi, hiw(0));
    check(lo, low());
    nd = 0;
    put_sample();
    host.rd_pair(hi, lo);
    check(hi, hiw(0));
    nd = 0;
    host.wr(8'h29, 32'hFFFFFFFF);
    host.rd_pair(hi, lo);
    check(hi, hiw(0));
    check(lo, low());
    // Sample arriving inside a pair read stays out of the low part
    host.rd(8'h28, hi);
    check(hi, hiw(0));
    seen = low();
    put_sample();
    host.rd(8'h29, lo);
    check(lo, 32'(seen));
    host.rd_pair(hi, lo);
    check(hi, hiw(0));
    check(lo, low());
    nd = 0;
    // Sleep ignores samples
    wr_ctrl(32'h00000001);
    put_sample();
    host.rd(8'h28, v);
    check(v, hiw(0));
    wr_ctrl(32'h00000000);
    $display("sample test done");
    // Unlatched interrupt follows the condition
    thresholdCrossed = 1'b1;
    tick(2);
    check(32'(intPin_n), 32'h0);
    host.rd(8'h28, v);
    check(v, hiw(1));
    thresholdCrossed = 1'b0;
    tick(2);
    check(32'(intPin_n), 32'h1);
    // Latched interrupt with record write
    intHoldEn = 1'b1;
    intRecordEn = 1'b1;
    tick(1);
    thresholdCrossed = 1'b1;
    seen = 0;
    for (int i = 0; i < 5; i++) begin
      tick(1);
      if (recordWriteStart === 1'b1) seen++;
      thresholdCrossed = 1'b0;
    end
    check(32'(seen), 32'h1);
    busy = 1;
    host.rd_pair(hi, lo);
    check(lo, low());
    check(hi, hiw(1));
    check(32'(intPin_n), 32'h0);
    recordWriteDone = 1'b1;
    tick(1);
    recordWriteDone = 1'b0;
    busy = 0;
    tick(2);
    host.rd(8'h29, v);
    check(v, low());
    host.set_access(1'b0);
    host.wr(8'h28, 32'h00000040);
    host.rd(8'h28, v);
    check(v, hiw(1));
    host.set_access(1'b1);
    host.wr(8'h28, 32'h00000040);
    host.rd(8'h28, v);
    check(v, hiw(0));
    check(32'(intPin_n), 32'h1);
    $display("interrupt test done");
    close_out();
  end
endmodule
`default_nettype wire
